// ===== hdl/tic_map.vh
// Purpose: Constants for the tile interrupt controller
// Assumes: AHB-Lite word registers, 32-bit data
// Notes: Offsets are byte addresses
`ifndef TIC_MAP_VH
`define TIC_MAP_VH
`define TIC_NSRC 7
`define TIC_OFF_PENDING 12'h000
`define TIC_OFF_MASK 12'h004
`define TIC_OFF_ENABLE 12'h008
`define TIC_OFF_SYSPC 12'h00C
`define TIC_OFF_USRPC 12'h010
`define TIC_OFF_WDMAX 12'h014
`define TIC_OFF_WDCNT 12'h018
`define TIC_OFF_REMAIN 12'h01C
`define TIC_OFF_CTRL 12'h020
`define TIC_B_REFILL 0
`define TIC_B_DONE 1
`define TIC_B_STEP 2
`define TIC_B_EXT 3
`define TIC_B_TIMER 4
`define TIC_B_NETRDY 5
`define TIC_B_PERF 6
`define TIC_EN_SYS 0
`define TIC_EN_USER 1
`define TIC_RST_MASK 7'h00
`define TIC_RST_EN 2'h0
`define TIC_RST_WDMAX 32'hFFFFFFFF
`define TIC_VEC_SHIFT 4
`endif

// ===== hdl/tic_prio.v
// Purpose: Highest-priority pick over gated requests
// Assumes: Bit 0 is the highest priority
// Notes: Combinational pick, no added latency
`timescale 1ns/1ps
module tic_prio #(
  parameter N = 7,
  parameter W = 3
) (
  input wire [N-1:0] req_i,
  output reg [W-1:0] idx_o,
  output reg any_o
);
  integer k;
  always @* begin
    idx_o = {W{1'b0}};
    any_o = 1'b0;
    for (k = N - 1; k >= 0; k = k - 1) begin
      if (req_i[k]) begin
        idx_o = k[W-1:0];
        any_o = 1'b1;
      end
    end
  end
endmodule

// ===== hdl/tic_top.v
// Purpose: Tile interrupt controller with AHB-Lite register slave
// Assumes: Single clock, synchronous active-high reset
// Notes: Pipeline interface is plain per-cycle strobes
//
// Our own choices: the register offsets and the AHB-Lite slave port.
`timescale 1ns/1ps
`include "tic_map.vh"
module tic_top #(
  parameter AW = 32,
  parameter PW = 32
) (
  input wire mclk_i,
  input wire rst_i,
  input wire hsel_i,
  input wire [31:0] haddr_i,
  input wire [1:0] htrans_i,
  input wire hwrite_i,
  input wire [2:0] hsize_i,
  input wire [31:0] hwdata_i,
  input wire hready_i,
  output reg [31:0] hrdata_o,
  output reg hreadyout_o,
  output reg hresp_o,
  input wire [PW-1:0] decode_pc_i,
  input wire decode_stall_i,
  input wire ex_sys_ret_i,
  input wire ex_user_ret_i,
  input wire ex_all_on_i,
  input wire ex_all_off_i,
  input wire ex_user_on_i,
  input wire ex_user_off_i,
  input wire refill_req_i,
  input wire step_req_i,
  input wire net_valid_out_i,
  input wire outbound_word_i,
  input wire ext_msg_i,
  input wire [7:0] event_bits_i,
  input wire wd_clear_i,
  output reg take_o,
  output reg [AW-1:0] vector_o,
  output reg redirect_o,
  output reg [PW-1:0] redirect_pc_o,
  output reg deadlock_detect_en_o
);
  localparam N = `TIC_NSRC;
  reg [N-1:0] pend_r;
  reg [N-1:0] mask_r;
  reg [1:0] en_r;
  reg [PW-1:0] syspc_r;
  reg [PW-1:0] usrpc_r;
  reg [31:0] wdmax_r;
  reg [31:0] wdcnt_r;
  reg [15:0] remain_r;
  reg timer_en_r;
  reg netrdy_q_r;
  reg [1:0] en_nxt;
  reg [N-1:0] pend_nxt;
  wire [N-1:0] lvl_gate;
  wire [N-1:0] live;
  wire [2:0] pick;
  wire any;
  wire take;
  wire wd_hit;
  wire [N-1:0] take_oh;
  // AHB slave state
  reg ph_wr_r;
  reg ph_rd_r;
  reg [11:0] ph_addr_r;
  wire ap = hsel_i && hready_i && htrans_i[1];
  wire wsel_pend = ph_wr_r && ph_addr_r == `TIC_OFF_PENDING;

  // Same-cycle instruction effects land before the next decode
  always @* begin
    en_nxt = en_r;
    if (ex_sys_ret_i)
      en_nxt[`TIC_EN_SYS] = 1'b1;
    if (ex_user_ret_i)
      en_nxt[`TIC_EN_USER] = 1'b1;
    if (ex_sys_ret_i || ex_user_ret_i || ex_all_on_i)
      en_nxt = 2'h3;
    if (ex_all_off_i)
      en_nxt = 2'h0;
    if (ex_user_on_i)
      en_nxt[`TIC_EN_USER] = 1'b1;
    if (ex_user_off_i)
      en_nxt[`TIC_EN_USER] = 1'b0;
  end

  // Gate by level: user source needs both enables, system needs sys only
  genvar g;
  generate
    for (g = 0; g < N; g = g + 1) begin : gate
      if (g == `TIC_B_NETRDY) begin : usr
        assign lvl_gate[g] = en_nxt[`TIC_EN_USER] & en_nxt[`TIC_EN_SYS];
      end else begin : sys
        assign lvl_gate[g] = en_nxt[`TIC_EN_SYS];
      end
    end
  endgenerate

  // Uses execute-stage enables so decode never fires against stale state
  assign live = pend_r & mask_r & lvl_gate;
  tic_prio #(
    .N(N),
    .W(3)
  ) u_prio (
    .req_i(live),
    .idx_o(pick),
    .any_o(any)
  );
  assign take = any && !decode_stall_i;
  assign take_oh = take ? ({{(N-1){1'b0}}, 1'b1} << pick) : {N{1'b0}};
  assign wd_hit = wdcnt_r == wdmax_r;

  always @* begin
    pend_nxt = pend_r & ~take_oh;
    // Software clear first so a same-cycle hardware set wins
    if (wsel_pend)
      pend_nxt = pend_nxt & ~hwdata_i[N-1:0];
    if (refill_req_i)
      pend_nxt[`TIC_B_REFILL] = 1'b1;
    if (step_req_i)
      pend_nxt[`TIC_B_STEP] = 1'b1;
    if (outbound_word_i && remain_r == 16'h0001)
      pend_nxt[`TIC_B_DONE] = 1'b1;
    if (ext_msg_i)
      pend_nxt[`TIC_B_EXT] = 1'b1;
    if (wd_hit && timer_en_r)
      pend_nxt[`TIC_B_TIMER] = 1'b1;
    pend_nxt[`TIC_B_NETRDY] = netrdy_q_r;
    pend_nxt[`TIC_B_PERF] = |event_bits_i;
  end

  always @(posedge mclk_i) begin
    if (rst_i) begin
      pend_r <= {N{1'b0}};
      mask_r <= `TIC_RST_MASK;
      en_r <= `TIC_RST_EN;
      syspc_r <= {PW{1'b0}};
      usrpc_r <= {PW{1'b0}};
      wdmax_r <= `TIC_RST_WDMAX;
      wdcnt_r <= 32'h00000000;
      remain_r <= 16'h0000;
      timer_en_r <= 1'b0;
      netrdy_q_r <= 1'b0;
      take_o <= 1'b0;
      vector_o <= {AW{1'b0}};
      redirect_o <= 1'b0;
      redirect_pc_o <= {PW{1'b0}};
      deadlock_detect_en_o <= 1'b1;
    end else begin
      netrdy_q_r <= net_valid_out_i;
      pend_r <= pend_nxt;
      en_r <= en_nxt;
      if (take) begin
        if (pick == `TIC_B_NETRDY) begin
          usrpc_r <= decode_pc_i;
          en_r[`TIC_EN_USER] <= 1'b0;
        end else begin
          syspc_r <= decode_pc_i;
          en_r <= 2'h0;
        end
      end
      take_o <= take;
      vector_o <= take ? ({{(AW-3){1'b0}}, pick} << `TIC_VEC_SHIFT) : vector_o;
      redirect_o <= ex_sys_ret_i | ex_user_ret_i;
      if (ex_sys_ret_i)
        redirect_pc_o <= syspc_r;
      else if (ex_user_ret_i)
        redirect_pc_o <= usrpc_r;
      // Deadlock watch stays armed in any handler; software owns it via ctrl
      deadlock_detect_en_o <= deadlock_detect_en_o;
      if (wd_clear_i || wd_hit)
        wdcnt_r <= 32'h00000000;
      else
        wdcnt_r <= wdcnt_r + 32'h00000001;
      if (outbound_word_i && remain_r != 16'h0000)
        remain_r <= remain_r - 16'h0001;
      if (ph_wr_r) begin
        case (ph_addr_r)
          `TIC_OFF_MASK: mask_r <= hwdata_i[N-1:0];
          `TIC_OFF_SYSPC: syspc_r <= hwdata_i[PW-1:0];
          `TIC_OFF_USRPC: usrpc_r <= hwdata_i[PW-1:0];
          `TIC_OFF_WDMAX: wdmax_r <= hwdata_i;
          `TIC_OFF_WDCNT: wdcnt_r <= hwdata_i;
          // Refractory: a word in this same cycle is not counted
          `TIC_OFF_REMAIN: remain_r <= hwdata_i[15:0];
          `TIC_OFF_CTRL: begin
            timer_en_r <= hwdata_i[0];
            deadlock_detect_en_o <= hwdata_i[1];
          end
          default: ;
        endcase
      end
    end
  end

  // AHB-Lite slave: zero wait states, always OKAY
  always @(posedge mclk_i) begin
    if (rst_i) begin
      ph_wr_r <= 1'b0;
      ph_rd_r <= 1'b0;
      ph_addr_r <= 12'h000;
      hrdata_o <= 32'h00000000;
      hreadyout_o <= 1'b1;
      hresp_o <= 1'b0;
    end else begin
      ph_wr_r <= ap && hwrite_i;
      ph_rd_r <= ap && !hwrite_i;
      ph_addr_r <= haddr_i[11:0];
      hreadyout_o <= 1'b1;
      hresp_o <= 1'b0;
      if (ap && !hwrite_i) begin
        case (haddr_i[11:0])
          `TIC_OFF_PENDING: hrdata_o <= {{(32-N){1'b0}}, pend_r};
          `TIC_OFF_MASK: hrdata_o <= {{(32-N){1'b0}}, mask_r};
          `TIC_OFF_ENABLE: hrdata_o <= {30'h0, ~en_r};
          `TIC_OFF_SYSPC: hrdata_o <= syspc_r;
          `TIC_OFF_USRPC: hrdata_o <= usrpc_r;
          `TIC_OFF_WDMAX: hrdata_o <= wdmax_r;
          `TIC_OFF_WDCNT: hrdata_o <= wdcnt_r;
          `TIC_OFF_REMAIN: hrdata_o <= {16'h0000, remain_r};
          `TIC_OFF_CTRL: hrdata_o <= {30'h0, deadlock_detect_en_o, timer_en_r};
          default: hrdata_o <= 32'h00000000;
        endcase
      end
    end
  end
endmodule

// ===== tb/tic_pipe.sv
// Purpose: Decode/execute stand-in
// Assumes: One instruction at a time
// Notes: PC held steady so saved PCs are exact
`timescale 1ns/1ps
module tic_pipe (
  input wire mclk_i,
  output logic [31:0] pc_o,
  output logic stall_o,
  output logic [5:0] ex_o
);
  initial begin
    pc_o = 32'h0;
    stall_o = 1'b0;
    ex_o = 6'h00;
  end
  task automatic at(input logic [31:0] p);
    @(posedge mclk_i);
    pc_o <= p;
  endtask
  task automatic hold(input logic s);
    @(posedge mclk_i);
    stall_o <= s;
  endtask
  // Bit order: sys ret, user ret, all on, all off, user on, user off
  task automatic fire(input int k);
    @(posedge mclk_i);
    ex_o <= 6'h01 << k;
    @(posedge mclk_i);
    ex_o <= 6'h00;
  endtask
endmodule

// ===== tb/tic_top_asserts.sv
// Purpose: Port checker for tic_top
// Assumes: Single clock, sync reset
// Notes: Bound below
`timescale 1ns/1ps
module tic_top_asserts #(
  parameter AW = 32
) (
  input wire mclk_i,
  input wire rst_i,
  input wire decode_stall_i,
  input wire ex_sys_ret_i,
  input wire ex_user_ret_i,
  input wire ex_all_on_i,
  input wire ex_all_off_i,
  input wire take_o,
  input wire [AW-1:0] vector_o,
  input wire redirect_o,
  input wire deadlock_detect_en_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (rst_i);
  vec_shape_a:
    assert property (take_o |-> vector_o[3:0] == 4'h0 && vector_o < 32'h70) else $error("vector");
  stall_hold_a:
    assert property (decode_stall_i |=> !take_o) else $error("take in stall");
  off_block_a:
    assert property (ex_all_off_i |=> !take_o) else $error("take after off");
  sys_ret_a:
    assert property (ex_sys_ret_i |=> redirect_o) else $error("sys return");
  usr_ret_a:
    assert property (ex_user_ret_i |=> redirect_o) else $error("user return");
  dl_keep_a:
    assert property (take_o && vector_o == 32'h50 |-> $stable(deadlock_detect_en_o))
      else $error("deadlock detect");
  rst_quiet_a:
    assert property ($fell(rst_i) |-> !take_o && !redirect_o) else $error("reset state");
  take_gap_a:
    assert property (take_o && vector_o != 32'h50 && !ex_sys_ret_i && !ex_user_ret_i &&
      !ex_all_on_i |=> !take_o) else $error("back to back take");
  cover property (take_o && vector_o == 32'h50);
  cover property (take_o && vector_o == 32'h40);
  cover property (redirect_o);
endmodule
bind tic_top tic_top_asserts #(.AW(AW)) i_tic_top_asserts (.mclk_i(mclk_i), .rst_i(rst_i),
  .decode_stall_i(decode_stall_i), .ex_sys_ret_i(ex_sys_ret_i), .ex_user_ret_i(ex_user_ret_i),
  .ex_all_on_i(ex_all_on_i), .ex_all_off_i(ex_all_off_i), .take_o(take_o), .vector_o(vector_o),
  .redirect_o(redirect_o), .deadlock_detect_en_o(deadlock_detect_en_o));

// ===== tb/tile_interrupt_control_bench.sv
// Purpose: Bench for tile interrupt controller
// Assumes: Pipeline model drives decode side
// Notes: Bus is zero wait but waits on ready
`timescale 1ns/1ps
`include "tic_map.vh"
module tile_interrupt_control_bench;
  logic mclk_i = 0, rst_i = 1, hsel = 0, hwrite = 0, netv = 0;
  logic [1:0] htrans = 0;
  logic [2:0] hsize = 0;
  logic [4:0] src = 0;
  logic [7:0] evb = 0;
  logic [31:0] haddr = 0, hwdata = 0, q;
  wire [31:0] hrdata, vec, rpc, pc;
  wire rdy, resp, take, red, dl, stall;
  wire [5:0] ex;
  int err_count = 0, compares = 0;
  always #2.5 mclk_i = ~mclk_i;
  tic_pipe i_tic_pipe (.mclk_i(mclk_i), .pc_o(pc), .stall_o(stall), .ex_o(ex));
  tic_top i_tic_top (.mclk_i(mclk_i), .rst_i(rst_i), .hsel_i(hsel), .haddr_i(haddr),
    .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(hsize), .hwdata_i(hwdata), .hready_i(rdy),
    .hrdata_o(hrdata), .hreadyout_o(rdy), .hresp_o(resp), .decode_pc_i(pc),
    .decode_stall_i(stall), .ex_sys_ret_i(ex[0]), .ex_user_ret_i(ex[1]), .ex_all_on_i(ex[2]),
    .ex_all_off_i(ex[3]), .ex_user_on_i(ex[4]), .ex_user_off_i(ex[5]), .refill_req_i(src[0]),
    .step_req_i(src[1]), .net_valid_out_i(netv), .outbound_word_i(src[3]), .ext_msg_i(src[2]),
    .event_bits_i(evb), .wd_clear_i(src[4]), .take_o(take), .vector_o(vec),
    .redirect_o(red), .redirect_pc_o(rpc), .deadlock_detect_en_o(dl));
  task automatic summarize;
    $display("compares %0d err_count %0d", compares, err_count);
    if (err_count == 0 && compares > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, g);
    compares++;
    if (g !== e) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge mclk_i);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {20'h00000, a};
    hwrite <= w;
    hsize <= 3'h2;
    do @(posedge mclk_i); while (rdy !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge mclk_i); while (rdy !== 1'b1);
    q = hrdata;
    chk("hresp", 32'h0, {31'h0, resp});
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0);
    chk($sformatf("reg %h", a), e, q);
  endtask
  task automatic pulse(input logic [4:0] s);
    @(posedge mclk_i);
    src <= s;
    @(posedge mclk_i);
    src <= 5'h00;
  endtask
  task automatic wtake(input logic [31:0] e);
    for (int i = 0; i < 60 && take !== 1'b1; i++) @(posedge mclk_i);
    chk("vector", e, take === 1'b1 ? vec : 32'hX);
  endtask
  task automatic wred(input logic [31:0] e);
    for (int i = 0; i < 20 && red !== 1'b1; i++) @(posedge mclk_i);
    chk("return pc", e, red === 1'b1 ? rpc : 32'hX);
  endtask
  initial begin
    repeat (4000) @(posedge mclk_i);
    err_count++;
    summarize;
  end
  initial begin
    repeat (10) @(posedge mclk_i);
    rst_i <= 1'b0;
    rd(`TIC_OFF_ENABLE, 32'h3);
    rd(`TIC_OFF_MASK, 32'h0);
    i_tic_pipe.at(32'h100);
    i_tic_pipe.fire(2);
    i_tic_pipe.fire(5);
    rd(`TIC_OFF_ENABLE, 32'h2);
    i_tic_pipe.fire(4);
    rd(`TIC_OFF_ENABLE, 32'h0);
    pulse(5'h04);
    i_tic_pipe.hold(1'b1);
    rd(`TIC_OFF_PENDING, 32'h8);
    xfer(1'b1, `TIC_OFF_MASK, 32'h7F);
    rd(`TIC_OFF_PENDING, 32'h8);
    i_tic_pipe.hold(1'b0);
    wtake(32'h30);
    rd(`TIC_OFF_PENDING, 32'h0);
    rd(`TIC_OFF_ENABLE, 32'h3);
    rd(`TIC_OFF_SYSPC, 32'h100);
    i_tic_pipe.fire(0);
    wred(32'h100);
    rd(`TIC_OFF_ENABLE, 32'h0);
    pulse(5'h03);
    wtake(32'h0);
    rd(`TIC_OFF_PENDING, 32'h4);
    i_tic_pipe.fire(0);
    wtake(32'h20);
    i_tic_pipe.fire(2);
    i_tic_pipe.at(32'h200);
    netv <= 1'b1;
    wtake(32'h50);
    chk("deadlock", 32'h1, {31'h0, dl});
    rd(`TIC_OFF_ENABLE, 32'h2);
    rd(`TIC_OFF_USRPC, 32'h200);
    rd(`TIC_OFF_PENDING, 32'h20);
    netv <= 1'b0;
    i_tic_pipe.at(32'h300);
    pulse(5'h04);
    wtake(32'h30);
    i_tic_pipe.fire(0);
    wred(32'h300);
    i_tic_pipe.fire(1);
    wred(32'h200);
    rd(`TIC_OFF_PENDING, 32'h0);
    evb <= 8'h10;
    wtake(32'h60);
    rd(`TIC_OFF_PENDING, 32'h40);
    evb <= 8'h00;
    rd(`TIC_OFF_PENDING, 32'h0);
    pulse(5'h04);
    xfer(1'b1, `TIC_OFF_PENDING, 32'h8);
    rd(`TIC_OFF_PENDING, 32'h0);
    i_tic_pipe.fire(2);
    xfer(1'b1, `TIC_OFF_REMAIN, 32'h2);
    pulse(5'h08);
    rd(`TIC_OFF_PENDING, 32'h0);
    pulse(5'h08);
    wtake(32'h10);
    rd(`TIC_OFF_REMAIN, 32'h0);
    i_tic_pipe.fire(2);
    xfer(1'b1, `TIC_OFF_WDMAX, 32'h14);
    xfer(1'b1, `TIC_OFF_WDCNT, 32'h0);
    xfer(1'b1, `TIC_OFF_CTRL, 32'h3);
    pulse(5'h10);
    rd(`TIC_OFF_WDCNT, 32'h1);
    rd(`TIC_OFF_CTRL, 32'h3);
    wtake(32'h40);
    i_tic_pipe.fire(3);
    xfer(1'b1, `TIC_OFF_CTRL, 32'h0);
    rst_i <= 1'b1;
    repeat (2) @(posedge mclk_i);
    rst_i <= 1'b0;
    rd(`TIC_OFF_MASK, 32'h0);
    rd(`TIC_OFF_ENABLE, 32'h3);
    rd(`TIC_OFF_PENDING, 32'h0);
    chk("deadlock", 32'h1, {31'h0, dl});
    summarize;
  end
endmodule
